// ### logic/crop_pkg.sv
package crop_pkg;

  // register byte addresses
  localparam logic [7:0] ANC_CROP_PIXELS_B_OFS = 8'hc8;
  localparam logic [7:0] ANC_CROP_LINES_B_OFS = 8'hcc;
  localparam logic [7:0] ACT_CROP_PIXELS_B_OFS = 8'hd0;
  localparam logic [7:0] ACT_CROP_LINES_B_OFS = 8'hd4;
  localparam logic [7:0] STOP_POLICY_A_OFS = 8'hd8;
  localparam logic [7:0] STOP_POLICY_B_OFS = 8'hdc;
  localparam logic [7:0] PORT_CTRL_OFS = 8'he0;
  localparam logic [7:0] FRAME_BUSY_OFS = 8'he4;
  localparam logic [7:0] PORT_STATUS_OFS = 8'he8;

  // writable bits of each register, reserved bits stay zero
  localparam logic [31:0] PIXELS_WMASK = 32'hf7ff87ff;
  localparam logic [31:0] LINES_WMASK = 32'h07ff07ff;
  localparam logic [31:0] STOP_WMASK = 32'hffffffff;
  localparam logic [31:0] CTRL_WMASK = 32'h00000001;
  localparam logic [31:0] REG_RESET = 32'h00000000;

  // field layout of the cropping registers
  localparam int CROP_ON_BIT = 15;
  localparam int SKIP_LSB = 0;
  localparam int SKIP_MSB = 10;
  localparam int KEEP_LSB = 16;
  localparam int KEEP_MSB = 26;
  localparam int TARGET_LSB = 28;
  localparam int TARGET_MSB = 31;
  localparam int PORT_EN_BIT = 0;

  // path select: ancillary vector in bits 15-0, active video in 31-16
  localparam logic ANC_PATH = 1'b0;
  localparam logic ACT_PATH = 1'b1;

  localparam int SRC_W = 4;
  localparam int CNT_W = 12;
  localparam int PIX_W = 24;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic anc;
    logic [SRC_W-1:0] src;
    logic sof;
    logic eof;
    logic sol;
    logic eol;
    logic [PIX_W-1:0] data;
  } beat_type;

  localparam int BEAT_W = $bits(beat_type);

endpackage : crop_pkg

// ### logic/video_capture_crop_and_stop.sv
// How it works
// [RULE1] crop enable bit 15 off passes data
// [RULE2] drop leading pixels given by bits 10-0
// [RULE3] then keep bits 26-16 pixels, drop rest
// [RULE4] software keeps skip plus keep below width
// [RULE5] ancillary: drop top lines from bits 10-0
// [RULE6] then keep bits 26-16 lines, drop rest
// [RULE7] software keeps line sums below region height
// [RULE8] active video top-line skip uses own register
// [RULE9] active cropper acts on target source 31-28
// [RULE10] disabled port finishes frames in progress
// [RULE11] stop vector bit per source, video high
// [RULE12] stop bit 0: finish frame then stop
// [RULE13] stop bit 1: stop source at once
// [RULE14] unfinished frame keeps port active forever
// [RULE15] ancillary cropper acts on target 31-28
// [RULE16] non-target sources pass through unmodified
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps

module crop_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_depth_chk
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem[rd_ptr_reg];
  assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk_sys_in)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data_in;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_out <= 1'b0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg <= count_next;
      in_ready_out <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule : crop_fifo

module video_capture_crop_and_stop
  import crop_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire beat_type in_beat_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output beat_type out_beat_out,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic port_active_out
);

  if (DEPTH < 2)
  begin : g_depth_chk
    $error("buffer depth must be at least 2");
  end

  logic [31:0] anc_crop_pixels_b_reg;
  logic [31:0] anc_crop_lines_b_reg;
  logic [31:0] act_crop_pixels_b_reg;
  logic [31:0] act_crop_lines_b_reg;
  logic [31:0] stop_policy_a_reg;
  logic [31:0] stop_policy_b_reg;
  logic [31:0] port_ctrl_reg;
  logic [31:0] frame_busy_reg;
  logic [31:0] frame_busy_next;
  logic [31:0] be_mask;
  logic [31:0] rd_mux;
  logic bus_write;
  logic [CNT_W-1:0] pcnt_reg [2];
  logic [CNT_W-1:0] lcnt_reg [2];

  // register slave: one cycle of waitrequest, answer on the next edge
  assign bus_write = avs_write_in & ~avs_waitrequest_out;
  assign be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      avs_waitrequest_out <= 1'b1;
    else
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) &
                               avs_waitrequest_out);
  end

  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] wmask);
    merge = ((old_val & ~be_mask) | (avs_writedata_in & be_mask)) & wmask;
  endfunction : merge

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      anc_crop_pixels_b_reg <= REG_RESET;
      anc_crop_lines_b_reg <= REG_RESET;
      act_crop_pixels_b_reg <= REG_RESET;
      act_crop_lines_b_reg <= REG_RESET;
      stop_policy_a_reg <= REG_RESET;
      stop_policy_b_reg <= REG_RESET;
      port_ctrl_reg <= REG_RESET;
    end
    else if (bus_write)
    begin
      if (avs_address_in == ANC_CROP_PIXELS_B_OFS)
        anc_crop_pixels_b_reg <= merge(anc_crop_pixels_b_reg, PIXELS_WMASK);
      else if (avs_address_in == ANC_CROP_LINES_B_OFS)
        anc_crop_lines_b_reg <= merge(anc_crop_lines_b_reg, LINES_WMASK);
      else if (avs_address_in == ACT_CROP_PIXELS_B_OFS)
        act_crop_pixels_b_reg <= merge(act_crop_pixels_b_reg, PIXELS_WMASK);
      else if (avs_address_in == ACT_CROP_LINES_B_OFS)
        act_crop_lines_b_reg <= merge(act_crop_lines_b_reg, LINES_WMASK);
      else if (avs_address_in == STOP_POLICY_A_OFS)
        stop_policy_a_reg <= merge(stop_policy_a_reg, STOP_WMASK);
      else if (avs_address_in == STOP_POLICY_B_OFS)
        stop_policy_b_reg <= merge(stop_policy_b_reg, STOP_WMASK);
      else if (avs_address_in == PORT_CTRL_OFS)
        port_ctrl_reg <= merge(port_ctrl_reg, CTRL_WMASK);
    end
  end

  always_comb
  begin
    if (avs_address_in == ANC_CROP_PIXELS_B_OFS)
      rd_mux = anc_crop_pixels_b_reg;
    else if (avs_address_in == ANC_CROP_LINES_B_OFS)
      rd_mux = anc_crop_lines_b_reg;
    else if (avs_address_in == ACT_CROP_PIXELS_B_OFS)
      rd_mux = act_crop_pixels_b_reg;
    else if (avs_address_in == ACT_CROP_LINES_B_OFS)
      rd_mux = act_crop_lines_b_reg;
    else if (avs_address_in == STOP_POLICY_A_OFS)
      rd_mux = stop_policy_a_reg;
    else if (avs_address_in == STOP_POLICY_B_OFS)
      rd_mux = stop_policy_b_reg;
    else if (avs_address_in == PORT_CTRL_OFS)
      rd_mux = port_ctrl_reg;
    else if (avs_address_in == FRAME_BUSY_OFS)
      rd_mux = frame_busy_reg;
    else if (avs_address_in == PORT_STATUS_OFS)
      rd_mux = {31'h0, port_active_out};
    else
      rd_mux = 32'h0;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      avs_readdata_out <= 32'h0;
    else if (avs_read_in & avs_waitrequest_out)
      avs_readdata_out <= rd_mux;
  end

  // per-beat cropping and stop decision
  logic path;
  logic [31:0] pix_cfg;
  logic [31:0] line_cfg;
  logic port_en;
  logic is_target;
  logic src_match;
  logic [CNT_W-1:0] hskip;
  logic [CNT_W-1:0] hkeep_end;
  logic [CNT_W-1:0] vskip;
  logic [CNT_W-1:0] vkeep_end;
  logic [CNT_W-1:0] hidx;
  logic [CNT_W-1:0] lidx;
  logic h_in;
  logic v_in;
  logic crop_keep;
  logic stop_bit;
  logic busy_bit;
  logic flow_keep;
  logic take;
  logic push;
  logic fifo_ready;
  beat_type push_beat;

  assign path = in_beat_in.anc ? ANC_PATH : ACT_PATH;
  assign pix_cfg = (path == ACT_PATH) ? act_crop_pixels_b_reg
                                      : anc_crop_pixels_b_reg;
  assign line_cfg = (path == ACT_PATH) ? act_crop_lines_b_reg
                                       : anc_crop_lines_b_reg;
  assign port_en = port_ctrl_reg[PORT_EN_BIT];
  // one target source per path and port
  assign src_match = (in_beat_in.src ==
                      pix_cfg[TARGET_MSB:TARGET_LSB]); // see [RULE9] [RULE15]
  assign is_target = pix_cfg[CROP_ON_BIT] & src_match; // see [RULE1]
  assign hskip = CNT_W'(pix_cfg[SKIP_MSB:SKIP_LSB]);
  assign hkeep_end = hskip + CNT_W'(pix_cfg[KEEP_MSB:KEEP_LSB]);
  assign vskip = CNT_W'(line_cfg[SKIP_MSB:SKIP_LSB]);
  assign vkeep_end = vskip + CNT_W'(line_cfg[KEEP_MSB:KEEP_LSB]);
  assign hidx = in_beat_in.sol ? '0 : pcnt_reg[path];
  assign lidx = in_beat_in.sof ? '0 : lcnt_reg[path];
  assign h_in = (hidx >= hskip) && (hidx < hkeep_end); // see [RULE2] [RULE3]
  // top lines of whichever region the path carries
  assign v_in = (lidx >= vskip) &&
                (lidx < vkeep_end); // see [RULE5] [RULE6] [RULE8]
  assign crop_keep = ~is_target | (h_in & v_in); // see [RULE16]
  // bit n of each half stands for source n
  assign stop_bit = stop_policy_b_reg[{path, in_beat_in.src}]; // see [RULE11]
  assign busy_bit = frame_busy_reg[{path, in_beat_in.src}];
  // a disabled port only lets a started frame run on; no new frames
  assign flow_keep = port_en | (busy_bit & ~stop_bit &
                     ~in_beat_in.sof); // see [RULE10] [RULE12] [RULE13]
  assign take = in_valid_in & in_ready_out;
  assign push = take & flow_keep & crop_keep;
  assign in_ready_out = fifo_ready;

  // markers follow the cropped window
  always_comb
  begin
    push_beat = in_beat_in;
    if (is_target)
    begin
      push_beat.sol = (hidx == hskip);
      push_beat.eol = (hidx == hkeep_end - CNT_W'(1));
      push_beat.sof = push_beat.sol & (lidx == vskip);
      push_beat.eof = push_beat.eol & (lidx == vkeep_end - CNT_W'(1));
    end
  end

  // pixel and line position of the target source on each path
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pcnt_reg[0] <= '0;
      pcnt_reg[1] <= '0;
      lcnt_reg[0] <= '0;
      lcnt_reg[1] <= '0;
    end
    else if (take & src_match)
    begin
      pcnt_reg[path] <= in_beat_in.eol ? '0 : hidx + CNT_W'(1);
      lcnt_reg[path] <= in_beat_in.eol ? lidx + CNT_W'(1) : lidx;
    end
  end

  // frame-in-progress per source, bit layout as the stop vector
  always_comb
  begin
    frame_busy_next = frame_busy_reg &
                      ~({32{~port_en}} & stop_policy_b_reg); // see [RULE13]
    if (take)
    begin
      if (in_beat_in.eof)
        frame_busy_next[{path, in_beat_in.src}] = 1'b0;
      else if (in_beat_in.sof & flow_keep)
        frame_busy_next[{path, in_beat_in.src}] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      frame_busy_reg <= 32'h0;
      port_active_out <= 1'b0;
    end
    else
    begin
      frame_busy_reg <= frame_busy_next;
      // a frame that never ends keeps the port up unless its source's stop bit is set
      port_active_out <= port_en | (|frame_busy_next); // see [RULE14]
    end
  end

  // buffer toward the memory mover, then a registered output stage
  logic [BEAT_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_take;

  assign fifo_take = ~out_valid_out | out_ready_in;

  crop_fifo #(
    .WIDTH(BEAT_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .in_data_in(push_beat),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_take)
  );

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      out_valid_out <= 1'b0;
      out_beat_out <= '0;
    end
    else if (fifo_take)
    begin
      out_valid_out <= fifo_valid;
      if (fifo_valid)
        out_beat_out <= beat_type'(fifo_data);
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  bypass_pass_a: assert property ( // see [RULE1]
    take & port_en & ~pix_cfg[CROP_ON_BIT] |-> push)
    else $error("uncropped beat was dropped");
  lead_drop_a: assert property ( // see [RULE2]
    take & is_target & (hidx < hskip) |-> !push)
    else $error("leading pixel not dropped");
  keep_count_a: assert property ( // see [RULE3]
    take & is_target & (hidx >= hkeep_end) |-> !push)
    else $error("pixel past kept count passed");
  top_lines_a: assert property ( // see [RULE5] [RULE8]
    take & is_target & (lidx < vskip) |-> !push)
    else $error("top line not dropped");
  lines_kept_a: assert property ( // see [RULE6]
    take & port_en & is_target & h_in & (lidx >= vskip) &
    (lidx < vkeep_end) |-> push)
    else $error("kept line pixel was dropped");
  other_src_a: assert property ( // see [RULE16] [RULE9] [RULE15]
    take & port_en & ~src_match |-> push && push_beat == in_beat_in)
    else $error("other source was altered");
  finish_frame_a: assert property ( // see [RULE10] [RULE12]
    take & ~port_en & busy_bit & ~stop_bit & ~in_beat_in.sof &
    ~is_target |-> push)
    else $error("started frame cut short");
  stop_now_a: assert property ( // see [RULE13]
    ~port_en & stop_bit & take |-> !push ##1
    !frame_busy_reg[{$past(path), $past(in_beat_in.src)}])
    else $error("immediate-stop source kept running");
  port_hold_a: assert property ( // see [RULE14]
    (|(frame_busy_reg & ~stop_policy_b_reg)) & ~take |=> port_active_out)
    else $error("port dropped with frame open");
  bus_answer_a: assert property (
    (avs_read_in | avs_write_in) & avs_waitrequest_out |=>
    !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer not one cycle");

  crop_seen_c: cover property (take & is_target & push);
  drain_seen_c: cover property (~port_en & busy_bit & push);
  full_seen_c: cover property (!fifo_ready ##1 fifo_ready);
  port_off_c: cover property (port_active_out ##1 !port_active_out);

endmodule : video_capture_crop_and_stop

// ### verif/crop_sink.sv
`timescale 1ns/1ps

module crop_sink
  import crop_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic [1:0] mode_in,
  input wire beat_type out_beat_in,
  input wire logic out_valid_in,
  output logic out_ready_out
);
  beat_type got_q[$];

  initial out_ready_out = 1'b1;

  // mode 0 takes every beat, 1 every other cycle, 2 stalls
  always @(posedge clk_sys_in)
  begin
    if (out_valid_in === 1'b1 && out_ready_out)
    begin
      got_q.push_back(out_beat_in);
    end
    out_ready_out <= mode_in == 2'd0 || (mode_in == 2'd1 && !out_ready_out);
  end
endmodule : crop_sink

// ### verif/video_capture_crop_and_stop_tb.sv
`timescale 1ns/1ps

module video_capture_crop_and_stop_tb;
  import crop_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] b;
    logic [31:0] e;
  } row_type;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdat;
  logic wreq;
  beat_type ib = '0;
  logic iv = 1'b0;
  logic irdy;
  beat_type ob;
  logic ov;
  logic ordy;
  logic act;
  logic [1:0] mode = 2'd0;
  int n_fail = 0;
  int num_checks = 0;
  logic [31:0] r;
  beat_type exp_q[$];
  logic c_on[2];
  logic [3:0] c_tg[2];
  int c_sp[2], c_kp[2], c_sl[2], c_kl[2];
  row_type rows[9] = '{
    '{8'hc8, 32'hffffffff, 4'hf, 32'hf7ff87ff},
    '{8'hcc, 32'hffffffff, 4'hf, 32'h07ff07ff},
    '{8'hd0, 32'hffffffff, 4'hf, 32'hf7ff87ff},
    '{8'hd4, 32'hffffffff, 4'hf, 32'h07ff07ff},
    '{8'hd8, 32'hffffffff, 4'hf, 32'hffffffff},
    '{8'hdc, 32'ha5a50f0f, 4'hf, 32'ha5a50f0f},
    '{8'hdc, 32'hffffffff, 4'h1, 32'ha5a50fff},
    '{8'he4, 32'hffffffff, 4'hf, 32'h00000000},
    '{8'hf0, 32'hffffffff, 4'hf, 32'h00000000}};

  always #5 clk_sys_in = ~clk_sys_in;

  video_capture_crop_and_stop #(.DEPTH(4)) u_video_capture_crop_and_stop (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .in_beat_in(ib), .in_valid_in(iv), .in_ready_out(irdy),
    .out_beat_out(ob), .out_valid_out(ov), .out_ready_in(ordy),
    .port_active_out(act));

  crop_sink u_crop_sink (.clk_sys_in(clk_sys_in), .mode_in(mode),
    .out_beat_in(ob), .out_valid_in(ov), .out_ready_out(ordy));

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    @(posedge clk_sys_in);
    adr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    do @(posedge clk_sys_in); while (wreq !== 1'b0);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic cfg(input logic an, input logic [3:0] tg, input logic on,
                     input int sp, kp, sl, kl);
    c_on[an] = on;
    c_tg[an] = tg;
    c_sp[an] = sp;
    c_kp[an] = kp;
    c_sl[an] = sl;
    c_kl[an] = kl;
    bus(1'b1, (an == ANC_PATH) ? ANC_CROP_PIXELS_B_OFS : ACT_CROP_PIXELS_B_OFS,
        {tg, 1'b0, 11'(kp), on, 4'h0, 11'(sp)}, 4'hf);
    bus(1'b1, (an == ANC_PATH) ? ANC_CROP_LINES_B_OFS : ACT_CROP_LINES_B_OFS,
        {5'h0, 11'(kl), 5'h0, 11'(sl)}, 4'hf);
  endtask : cfg

  // beats b0..b1-1 of a w by h frame; ex says whether they may come out
  task automatic send(input logic an, input logic [3:0] s,
                      input int w, h, b0, b1, input logic ex);
    beat_type t, e;
    int ln, px;
    logic cut, keep;
    for (int i = b0; i < b1; i++)
    begin
      ln = i / w;
      px = i % w;
      t = '0;
      t.anc = (an == ANC_PATH);
      t.src = s;
      t.data = {s, 8'(ln), 12'(px)};
      t.sol = px == 0;
      t.eol = px == w - 1;
      t.sof = i == 0;
      t.eof = i == w * h - 1;
      e = t;
      cut = c_on[an] && s == c_tg[an];
      keep = ln >= c_sl[an] && ln < c_sl[an] + c_kl[an] &&
             px >= c_sp[an] && px < c_sp[an] + c_kp[an];
      if (cut)
      begin
        e.sol = px == c_sp[an];
        e.eol = px == c_sp[an] + c_kp[an] - 1;
        e.sof = e.sol && ln == c_sl[an];
        e.eof = e.eol && ln == c_sl[an] + c_kl[an] - 1;
      end
      if (ex && (!cut || keep))
        exp_q.push_back(e);
      ib <= t;
      iv <= 1'b1;
      do @(posedge clk_sys_in); while (irdy !== 1'b1);
    end
    iv <= 1'b0;
  endtask : send

  task automatic drain(input string m);
    int k;
    k = 0;
    while (u_crop_sink.got_q.size() < exp_q.size() && k < 400)
    begin
      @(posedge clk_sys_in);
      k++;
    end
    repeat (6) @(posedge clk_sys_in);
    chk(u_crop_sink.got_q.size() == exp_q.size(), "beat count");
    foreach (exp_q[i])
      if (i < u_crop_sink.got_q.size())
        chk(u_crop_sink.got_q[i] === exp_q[i], "beat value");
    exp_q.delete();
    u_crop_sink.got_q.delete();
    $display("test %s done", m);
  endtask : drain

  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  initial
  begin
    #300000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end

  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    chk(wreq === 1'b1 && ov === 1'b0 && act === 1'b0 && irdy === 1'b0 &&
        rdat === 32'h0, "reset outputs");
    rst_b_in <= 1'b1;
    foreach (rows[i])
    begin
      bus(1'b0, rows[i].a, 32'h0, 4'hf);
      chk(r === 32'h0, "reset value");
    end
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].d, rows[i].b);
      bus(1'b0, rows[i].a, 32'h0, 4'hf);
      chk(r === rows[i].e, "register readback");
    end
    $display("test registers done");
    bus(1'b1, STOP_POLICY_B_OFS, 32'h0, 4'hf);
    bus(1'b1, PORT_CTRL_OFS, 32'h1, 4'hf);
    cfg(ACT_PATH, 4'd5, 1'b0, 2, 3, 1, 2);
    send(ACT_PATH, 4'd5, 8, 4, 0, 32, 1'b1);
    drain("bypass");
    cfg(ACT_PATH, 4'd5, 1'b1, 2, 3, 1, 2);
    cfg(ANC_PATH, 4'd5, 1'b1, 1, 4, 0, 3);
    mode <= 2'd1;
    send(ACT_PATH, 4'd5, 8, 4, 0, 32, 1'b1);
    drain("video crop");
    send(ANC_PATH, 4'd5, 8, 4, 0, 32, 1'b1);
    drain("anc crop");
    send(ACT_PATH, 4'd6, 8, 4, 0, 32, 1'b1);
    send(ANC_PATH, 4'd6, 8, 4, 0, 32, 1'b1);
    drain("other source");
    mode <= 2'd2;
    fork
      send(ACT_PATH, 4'd6, 12, 1, 0, 12, 1'b1);
    join_none
    repeat (30) @(posedge clk_sys_in);
    chk(irdy === 1'b0, "buffer full not refused");
    mode <= 2'd0;
    wait fork;
    drain("backpressure");
    send(ACT_PATH, 4'd2, 4, 3, 0, 6, 1'b1);
    drain("frame start");
    bus(1'b1, PORT_CTRL_OFS, 32'h0, 4'hf);
    repeat (50) @(posedge clk_sys_in);
    chk(act === 1'b1, "port stopped mid frame");
    bus(1'b0, FRAME_BUSY_OFS, 32'h0, 4'hf);
    chk(r === 32'h0004_0000, "busy vector");
    send(ACT_PATH, 4'd2, 4, 3, 6, 12, 1'b1);
    drain("finish frame");
    chk(act === 1'b0, "port still active");
    send(ACT_PATH, 4'd2, 4, 3, 0, 12, 1'b0);
    drain("no new frame");
    bus(1'b1, PORT_CTRL_OFS, 32'h1, 4'hf);
    bus(1'b1, STOP_POLICY_B_OFS, 32'h0080_0008, 4'hf);
    send(ACT_PATH, 4'd7, 4, 3, 0, 6, 1'b1);
    send(ANC_PATH, 4'd3, 4, 3, 0, 6, 1'b1);
    drain("partial frames");
    chk(act === 1'b1, "port inactive while enabled");
    bus(1'b1, PORT_CTRL_OFS, 32'h0, 4'hf);
    repeat (4) @(posedge clk_sys_in);
    chk(act === 1'b0, "no immediate stop");
    send(ACT_PATH, 4'd7, 4, 3, 6, 12, 1'b0);
    send(ANC_PATH, 4'd3, 4, 3, 6, 12, 1'b0);
    drain("immediate stop");
    // reset in mid-run with the port enabled
    bus(1'b1, PORT_CTRL_OFS, 32'h1, 4'hf);
    repeat (2) @(posedge clk_sys_in);
    chk(act === 1'b1, "port not active after enable");
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk(wreq === 1'b1 && ov === 1'b0 && act === 1'b0 && irdy === 1'b0 &&
        rdat === 32'h0, "mid-run reset outputs");
    rst_b_in <= 1'b1;
    bus(1'b0, PORT_CTRL_OFS, 32'h0, 4'hf);
    chk(r === 32'h0, "port enable after reset");
    bus(1'b0, STOP_POLICY_B_OFS, 32'h0, 4'hf);
    chk(r === 32'h0, "stop vector after reset");
    $display("test reset done");
    conclude();
  end
endmodule : video_capture_crop_and_stop_tb
